/* File: hdl/dadc_conv.sv */
// Conversion timer and output coding for one internal converter.
// Assumes start is a one-cycle pulse and raw_value is the held sample.
`timescale 1ns/100ps
module dadc_conv
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic start,
   input wire logic [dadc_pkg::RAW_W-1:0] raw_value,
   // Result
   output logic done,
   output logic [dadc_pkg::RES_W-1:0] result
);
   import dadc_pkg::*;

   dadc_conv_s conv_r;
   dadc_conv_s conv_nxt;

   always_comb
   begin
      conv_nxt = conv_r;
      conv_nxt.done = 1'b0;
      if (start && !conv_r.active)
      begin
         conv_nxt.active = 1'b1;
         conv_nxt.cnt = '0;
         if ($signed(raw_value) > $signed(RAW_MAX))
            conv_nxt.result = CODE_POS_FS;
         else if ($signed(raw_value) < $signed(RAW_MIN))
            conv_nxt.result = CODE_NEG_FS;
         else
            conv_nxt.result = raw_value[RES_W-1:0];
      end
      else if (conv_r.active)
      begin
         if (conv_r.cnt == CONV_CYCLES - 6'h01)
         begin
            conv_nxt.active = 1'b0;
            conv_nxt.done = 1'b1;
         end
         else
            conv_nxt.cnt = conv_r.cnt + 6'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         conv_r <= '0;
      else
         conv_r <= conv_nxt;
   end

   assign done = conv_r.done;
   assign result = conv_r.result;
endmodule

/* File: hdl/dadc_ctrl.sv */
// Digital interface control of a dual 16-bit sampling converter.
// Assumes converter pins are asynchronous and sample_in is on clk.
// Overview of operation
// - A rising conversion start samples chain select: high picks select-framed, low chain.
// - With chain select tied to conversion start, the pre-edge level makes chain mode win.
// - Select-framed readout works on three lines, framed by conversion start low.
// - Select-framed readout also works with chain select as a separate readout select.
// - In chain mode chain select is the cascade data input, shifted like a register.
// - In chain mode one internal converter can cascade into the other on one line set.
// - With busy enabled a start bit precedes the result bits; in select-framed readout it also signals completion.
// - Select-framed busy is enabled when either select line is low at conversion end.
// - Chain busy is enabled when the shift clock is high at the conversion start edge.
// - Each converter powers down at the end of every conversion.
// - Conversions are timed by an internal clock, never by the shift clock.
// - Results are two's complement and saturate at 0x7FFF and 0x8000.
// - Select-framed readout shows the MSB (start bit with busy) on select, advances on falls, ends at 16 falls (17 with busy) or deselect.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module dadc_ctrl
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire dadc_pkg::dadc_avs_req_s avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Converter pins
   input wire logic [dadc_pkg::NUM_CH-1:0] convert_start_in,
   input wire logic [dadc_pkg::NUM_CH-1:0] chain_select_in,
   input wire logic [dadc_pkg::NUM_CH-1:0] shift_clock_in,
   output logic [dadc_pkg::NUM_CH-1:0] result_serial_out,
   output logic [dadc_pkg::NUM_CH-1:0] result_serial_oe,
   // Converter core
   input wire logic [dadc_pkg::NUM_CH-1:0][dadc_pkg::RAW_W-1:0] sample_in,
   output logic [dadc_pkg::NUM_CH-1:0] power_down_out,
   // Interrupt
   output logic irq
);
   import dadc_pkg::*;

   dadc_top_s top_r;
   dadc_top_s top_nxt;

   dadc_pins_s [NUM_CH-1:0] pins_raw;
   dadc_pins_s [NUM_CH-1:0] pins_s;
   logic [NUM_CH-1:0] conv_start;
   logic [NUM_CH-1:0] conv_done;
   logic [NUM_CH-1:0][RES_W-1:0] conv_result;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : gen_ch
         assign pins_raw[g].convert_start = convert_start_in[g];
         assign pins_raw[g].chain_select = chain_select_in[g];
         assign pins_raw[g].shift_clock = shift_clock_in[g];

         dadc_sync u_sync
         (
            .clk(clk),
            .nrst(nrst),
            .pins_async(pins_raw[g]),
            .pins_sync(pins_s[g])
         );

         dadc_conv u_conv
         (
            .clk(clk),
            .nrst(nrst),
            .start(conv_start[g]),
            .raw_value(sample_in[g]),
            .done(conv_done[g]),
            .result(conv_result[g])
         );
      end
   endgenerate

   always_comb
   begin
      dadc_pins_s p;
      dadc_pins_s q;
      logic cnv_rise;
      logic sck_rise;
      logic sck_fall;
      logic sel;
      logic link_in;
      logic end_read;
      logic [EV_W-1:0] ev;
      logic [EV_W-1:0] clr;
      logic [NUM_CH*STAT_CH_W-1:0] status;
      p = '0;
      q = '0;
      cnv_rise = 1'b0;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      sel = 1'b0;
      link_in = 1'b0;
      end_read = 1'b0;
      ev = '0;
      clr = '0;
      status = '0;
      conv_start = '0;
      top_nxt = top_r;

      for (int i = 0; i < NUM_CH; i++)
      begin
         p = pins_s[i];
         q = top_r.ch[i].last;
         cnv_rise = p.convert_start & ~q.convert_start;
         sck_rise = p.shift_clock & ~q.shift_clock;
         sck_fall = ~p.shift_clock & q.shift_clock;
         sel = ~(p.convert_start & p.chain_select);
         if (i == 0 && top_r.int_chain)
            link_in = top_r.ch[1].sdo;
         else
            link_in = p.chain_select;
         end_read = 1'b0;
         top_nxt.ch[i].last = p;

         // A conversion in flight is never restarted or stopped by the pins
         if (cnv_rise && top_r.ch[i].state != CH_CONV)
         begin
            conv_start[i] = 1'b1;
            top_nxt.ch[i].state = CH_CONV;
            top_nxt.ch[i].chain_mode = ~q.chain_select;
            top_nxt.ch[i].busy_en = ~q.chain_select & q.shift_clock;
            top_nxt.ch[i].sdo_oe = 1'b0;
            top_nxt.ch[i].powered_down = 1'b0;
         end
         else
         begin
            case (top_r.ch[i].state)
               CH_CONV:
               begin
                  if (conv_done[i])
                  begin
                     top_nxt.ch[i].powered_down = 1'b1;
                     top_nxt.ch[i].result = conv_result[i];
                     ev[EV_CONV_DONE0 + i] = 1'b1;
                     if (top_r.ch[i].chain_mode)
                     begin
                        if (top_r.ch[i].busy_en)
                           top_nxt.ch[i].shreg = {START_BIT_CHAIN, conv_result[i]};
                        else
                           top_nxt.ch[i].shreg = {conv_result[i], 1'b0};
                        top_nxt.ch[i].state = CH_CHAIN;
                     end
                     else if (sel)
                     begin
                        top_nxt.ch[i].busy_en = 1'b1;
                        top_nxt.ch[i].shreg = {START_BIT_CS, conv_result[i]};
                        top_nxt.ch[i].bit_cnt = BITS_BUSY;
                        top_nxt.ch[i].sdo_oe = 1'b1;
                        top_nxt.ch[i].state = CH_SHIFT;
                     end
                     else
                     begin
                        top_nxt.ch[i].busy_en = 1'b0;
                        top_nxt.ch[i].shreg = {conv_result[i], 1'b0};
                        top_nxt.ch[i].bit_cnt = BITS_PLAIN;
                        top_nxt.ch[i].state = CH_WAIT;
                     end
                  end
               end
               CH_WAIT:
               begin
                  if (sel)
                  begin
                     top_nxt.ch[i].sdo_oe = 1'b1;
                     top_nxt.ch[i].state = CH_SHIFT;
                  end
               end
               CH_SHIFT:
               begin
                  if (!sel)
                     end_read = 1'b1;
                  else if (sck_fall)
                  begin
                     if (top_r.ch[i].bit_cnt == BITS_LAST)
                        end_read = 1'b1;
                     else
                     begin
                        top_nxt.ch[i].shreg = {top_r.ch[i].shreg[SHREG_W-2:0], 1'b0};
                        top_nxt.ch[i].bit_cnt = top_r.ch[i].bit_cnt - 5'h01;
                     end
                  end
               end
               CH_CHAIN:
               begin
                  if (sck_rise)
                     top_nxt.ch[i].link_bit = link_in;
                  // Without busy only the upper 16 bits form the stage, so a cascade
                  // passes exactly one 16-bit word per converter
                  if (sck_fall && top_r.ch[i].busy_en)
                     top_nxt.ch[i].shreg =
                        {top_r.ch[i].shreg[SHREG_W-2:0], top_r.ch[i].link_bit};
                  else if (sck_fall)
                     top_nxt.ch[i].shreg =
                        {top_r.ch[i].shreg[SHREG_W-2:1], top_r.ch[i].link_bit, 1'b0};
                  // Framed by conversion start low, so shared lines stay free otherwise
                  top_nxt.ch[i].sdo_oe = ~p.convert_start;
               end
               default:
               begin
                  top_nxt.ch[i].sdo_oe = 1'b0;
               end
            endcase
         end

         if (end_read)
         begin
            top_nxt.ch[i].sdo_oe = 1'b0;
            top_nxt.ch[i].state = CH_IDLE;
            ev[EV_READ_DONE0 + i] = 1'b1;
         end
         top_nxt.ch[i].sdo = top_nxt.ch[i].shreg[SHREG_W-1];

         status[i*STAT_CH_W + ST_CHAIN_MODE] = top_r.ch[i].chain_mode;
         status[i*STAT_CH_W + ST_BUSY_EN] = top_r.ch[i].busy_en;
         status[i*STAT_CH_W + ST_CONVERTING] = top_r.ch[i].state == CH_CONV;
         status[i*STAT_CH_W + ST_POWERED_DOWN] = top_r.ch[i].powered_down;
         status[i*STAT_CH_W + ST_READING] = top_r.ch[i].sdo_oe;
      end

      // Register access: one wait cycle, then the answer stands for the completing edge
      top_nxt.waitreq = 1'b1;
      if ((avs_req.read || avs_req.write) && top_r.waitreq)
      begin
         top_nxt.waitreq = 1'b0;
         if (!avs_req.read)
            top_nxt.readdata = top_r.readdata;
         else if (avs_req.address == OFS_CTRL)
            top_nxt.readdata = {31'h00000000, top_r.int_chain};
         else if (avs_req.address == OFS_STATUS)
            top_nxt.readdata = {16'h0000, status};
         else if (avs_req.address == OFS_RESULT0)
            top_nxt.readdata = {16'h0000, top_r.ch[0].result};
         else if (avs_req.address == OFS_RESULT1)
            top_nxt.readdata = {16'h0000, top_r.ch[1].result};
         else if (avs_req.address == OFS_INT_STAT)
            top_nxt.readdata = {28'h0000000, top_r.int_stat};
         else if (avs_req.address == OFS_INT_MASK)
            top_nxt.readdata = {28'h0000000, top_r.int_mask};
         else
            top_nxt.readdata = 32'h00000000;
      end

      if (avs_req.write && !top_r.waitreq && avs_req.byteenable[0])
      begin
         if (avs_req.address == OFS_CTRL)
            top_nxt.int_chain = avs_req.writedata[CTRL_INT_CHAIN_BIT];
         else if (avs_req.address == OFS_INT_STAT)
            clr = avs_req.writedata[EV_W-1:0];
         else if (avs_req.address == OFS_INT_MASK)
            top_nxt.int_mask = avs_req.writedata[EV_W-1:0];
      end

      // A new event outranks a clear written in the same cycle
      top_nxt.int_stat = (top_r.int_stat & ~clr) | ev;
      top_nxt.irq = |(top_nxt.int_stat & top_nxt.int_mask);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         top_r <= '0;
         for (int i = 0; i < NUM_CH; i++)
         begin
            top_r.ch[i].state <= CH_IDLE;
            top_r.ch[i].powered_down <= 1'b1;
         end
         top_r.int_chain <= CTRL_INT_CHAIN_RESET;
         top_r.int_mask <= INT_MASK_RESET;
         top_r.waitreq <= 1'b1;
      end
      else
         top_r <= top_nxt;
   end

   generate
      for (g = 0; g < NUM_CH; g++)
      begin : gen_out
         assign result_serial_out[g] = top_r.ch[g].sdo;
         assign result_serial_oe[g] = top_r.ch[g].sdo_oe;
         assign power_down_out[g] = top_r.ch[g].powered_down;
      end
   endgenerate

   assign avs_readdata = top_r.readdata;
   assign avs_waitrequest = top_r.waitreq;
   assign irq = top_r.irq;
endmodule

/* File: hdl/dadc_sync.sv */
// Two-stage synchroniser for one channel's converter pins.
// Assumes the pins are asynchronous to clk; only the second stage is read.
`timescale 1ns/100ps
module dadc_sync
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pins
   input wire dadc_pkg::dadc_pins_s pins_async,
   output dadc_pkg::dadc_pins_s pins_sync
);
   import dadc_pkg::*;

   dadc_sync_s sync_r;
   dadc_sync_s sync_nxt;

   always_comb
   begin
      sync_nxt.meta = pins_async;
      sync_nxt.stable = sync_r.meta;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sync_r <= '0;
      else
         sync_r <= sync_nxt;
   end

   assign pins_sync = sync_r.stable;
endmodule

/* File: inc/dadc_pkg.sv */
// Shared constants and types for the dual converter serial mode control.
// Assumes a 40 MHz system clock and word-aligned Avalon-MM byte addresses.
package dadc_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int CONV_TIME_NS = 500;
   localparam logic [5:0] CONV_CYCLES =
      6'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Data path widths and codes
   localparam int NUM_CH = 2;
   localparam int RES_W = 16;
   localparam int RAW_W = 18;
   localparam int SHREG_W = 17;
   localparam logic [RAW_W-1:0] RAW_MAX = 18'h07FFF;
   localparam logic [RAW_W-1:0] RAW_MIN = 18'h38000;
   localparam logic [RES_W-1:0] CODE_POS_FS = 16'h7FFF;
   localparam logic [RES_W-1:0] CODE_NEG_FS = 16'h8000;
   localparam logic [4:0] BITS_PLAIN = 5'h10;
   localparam logic [4:0] BITS_BUSY = 5'h11;
   localparam logic [4:0] BITS_LAST = 5'h01;
   localparam logic START_BIT_CS = 1'b0;
   localparam logic START_BIT_CHAIN = 1'b1;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RESULT0 = 8'h08;
   localparam logic [7:0] OFS_RESULT1 = 8'h0C;
   localparam logic [7:0] OFS_INT_STAT = 8'h10;
   localparam logic [7:0] OFS_INT_MASK = 8'h14;

   // Fields and reset values
   localparam int CTRL_INT_CHAIN_BIT = 0;
   localparam logic CTRL_INT_CHAIN_RESET = 1'b0;
   localparam int EV_W = 4;
   localparam int EV_CONV_DONE0 = 0;
   localparam int EV_READ_DONE0 = 2;
   localparam logic [EV_W-1:0] INT_MASK_RESET = 4'h0;
   localparam int STAT_CH_W = 8;
   localparam int ST_CHAIN_MODE = 0;
   localparam int ST_BUSY_EN = 1;
   localparam int ST_CONVERTING = 2;
   localparam int ST_POWERED_DOWN = 3;
   localparam int ST_READING = 4;

   typedef struct packed {
      logic convert_start;
      logic chain_select;
      logic shift_clock;
   } dadc_pins_s;

   typedef enum logic [4:0] {
      CH_IDLE = 5'h01,
      CH_CONV = 5'h02,
      CH_WAIT = 5'h04,
      CH_SHIFT = 5'h08,
      CH_CHAIN = 5'h10
   } dadc_ch_e;

   typedef struct packed {
      dadc_ch_e state;
      logic chain_mode;
      logic busy_en;
      logic [SHREG_W-1:0] shreg;
      logic [4:0] bit_cnt;
      logic link_bit;
      logic sdo;
      logic sdo_oe;
      logic powered_down;
      logic [RES_W-1:0] result;
      dadc_pins_s last;
   } dadc_ch_s;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } dadc_avs_req_s;

   typedef struct packed {
      logic active;
      logic [5:0] cnt;
      logic done;
      logic [RES_W-1:0] result;
   } dadc_conv_s;

   typedef struct packed {
      dadc_pins_s meta;
      dadc_pins_s stable;
   } dadc_sync_s;

   typedef struct packed {
      dadc_ch_s [NUM_CH-1:0] ch;
      logic int_chain;
      logic [EV_W-1:0] int_stat;
      logic [EV_W-1:0] int_mask;
      logic irq;
      logic waitreq;
      logic [31:0] readdata;
   } dadc_top_s;

endpackage

/* File: verification/dadc_ctrl_chk.sv */
// Checker for the converter control: bus handshake and pin timing.
// Assumes it is bound to dadc_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module dadc_ctrl_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Watched ports
   input wire dadc_pkg::dadc_avs_req_s avs_req,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] result_serial_oe,
   input wire logic [1:0] power_down_out
);
   import dadc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic rq;
   assign rq = avs_req.read | avs_req.write;
   a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_ans: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one wait cycle");
   a_wait_idle: assert property (!rq && avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer without a request");
   a_read_unmapped: assert property (!avs_waitrequest && avs_req.read
      && avs_req.address == 8'h20 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_read_upper: assert property (!avs_waitrequest && avs_req.read
      |-> avs_readdata[31:16] == 16'h0)
      else $error("upper read data bits not zero");
   a_conv_len: assert property ($fell(power_down_out[0])
      |-> ##18 !power_down_out[0] ##[1:3] power_down_out[0])
      else $error("conversion length wrong");
   a_oe_conv: assert property (!power_down_out[1] && !$past(power_down_out[1])
      |-> !result_serial_oe[1])
      else $error("result driven during conversion");
   a_oe_rise: assert property ($rose(result_serial_oe[0]) |-> power_down_out[0])
      else $error("readout while not powered down");
endmodule
bind dadc_ctrl dadc_ctrl_chk i_dadc_ctrl_chk (.clk(clk), .nrst(nrst), .avs_req(avs_req),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .result_serial_oe(result_serial_oe), .power_down_out(power_down_out));

/* File: verification/dadc_host_model.sv */
// Host side of the converter pins: start, select, shift clock, result line.
// Assumes a shared result line with a pull-up; pins change after clk rises.
`timescale 1ns/100ps
module dadc_host_model
(
   // Clock
   input wire logic clk,
   // Pins to the device
   output logic [1:0] cnv,
   output logic [1:0] sel,
   output logic [1:0] sck,
   // Result line
   input wire logic [1:0] sdo,
   input wire logic [1:0] oe
);
   logic [1:0] line;
   // Released pin reads the pull-up level, never the last bit
   assign line = (sdo & oe) | ~oe;
   initial
   begin
      cnv = 2'h0;
      sel = 2'h3;
      sck = 2'h0;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // mode set up before the start edge, or tied to it
   task automatic start(input int ch, input logic s, input logic k, input logic tie);
      cnv[ch] <= 1'b0;
      sel[ch] <= tie ? 1'b0 : s;
      sck[ch] <= k;
      idle(6);
      cnv[ch] <= 1'b1;
      if (tie) sel[ch] <= 1'b1;
      idle(4);
      sck[ch] <= 1'b0;
   endtask
   // no busy bit: wait out the longest conversion
   task automatic wait_conv();
      idle(30);
   endtask
   // bits taken while the shift clock is high, 200 ns period
   task automatic rd(input int ch, input int n, output logic [16:0] w);
      w = 17'h0;
      repeat (n)
      begin
         sck[ch] <= 1'b1;
         idle(4);
         w = {w[15:0], line[ch]};
         sck[ch] <= 1'b0;
         idle(4);
      end
   endtask
   // both shift clocks run together, channel 0 line carries both words
   task automatic rd2(output logic [31:0] w);
      w = 32'h0;
      repeat (32)
      begin
         sck <= 2'h3;
         idle(4);
         w = {w[30:0], line[0]};
         sck <= 2'h0;
         idle(4);
      end
   endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for dadc_ctrl with a host pin model and bus tasks.
// Assumes a 40 MHz clock and the register map of the design package.
`timescale 1ns/100ps
module testbench;
   import dadc_pkg::*;
   logic clk;
   logic nrst;
   dadc_avs_req_s avs_req;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] cnv, sel, sck, sdo, oe, pd;
   logic [1:0][RAW_W-1:0] sample_in;
   logic irq;
   int num_errors;
   int total_checks;
   logic [31:0] seed;
   logic [31:0] d;
   logic [17:0] s0, s1;
   logic [16:0] w17;
   logic [31:0] w32;
   logic [17:0] tbl [4] = '{18'h1FFFF, 18'h20000, 18'h07FFF, 18'h38000};
   dadc_ctrl i_dadc_ctrl (.clk(clk), .nrst(nrst), .avs_req(avs_req),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .convert_start_in(cnv), .chain_select_in(sel), .shift_clock_in(sck),
      .result_serial_out(sdo), .result_serial_oe(oe), .sample_in(sample_in),
      .power_down_out(pd), .irq(irq));
   dadc_host_model i_dadc_host_model (.clk(clk), .cnv(cnv), .sel(sel), .sck(sck),
      .sdo(sdo), .oe(oe));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   task automatic final_report;
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Reference coding: clip the signed sample to 16 bits
   function automatic logic [15:0] sat(input logic [17:0] s);
      int v;
      v = $signed(s);
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return 16'(v);
   endfunction
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      int t;
      avs_req.read <= !wr;
      avs_req.write <= wr;
      avs_req.address <= a;
      avs_req.byteenable <= 4'hF;
      avs_req.writedata <= wd;
      for (t = 0; t < 50; t++)
      begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
      // Idle edge so a following call never reassigns read or write in this step
      @(posedge clk);
      if (t == 50)
      begin
         num_errors++;
         final_report();
      end
   endtask
   // Modes: 0/1 three-line, 2/3 four-line, 4/5 chain, 6 tied; odd 1,3,5 busy
   task automatic run(input int ch, input int m, input logic [17:0] smp);
      logic ch_m, busy;
      logic [16:0] w;
      logic [15:0] res;
      ch_m = m >= 4;
      busy = m == 1 || m == 3 || m == 5;
      res = sat(smp);
      sample_in[ch] <= smp;
      i_dadc_host_model.start(ch, !ch_m, m == 5, m == 6);
      if (m == 1) i_dadc_host_model.cnv[ch] <= 1'b0;
      if (m == 3) i_dadc_host_model.sel[ch] <= 1'b0;
      i_dadc_host_model.wait_conv();
      bus(1'b0, OFS_STATUS, 32'h0, d);
      chk("chain_mode", d[8*ch+ST_CHAIN_MODE], ch_m);
      chk("busy_en", d[8*ch+ST_BUSY_EN], busy);
      chk("power_down", pd[ch], 1'b1);
      chk("oe_end", oe[ch], busy && !ch_m);
      bus(1'b0, ch ? OFS_RESULT1 : OFS_RESULT0, 32'h0, d);
      chk("result_reg", d, {16'h0, res});
      if (m == 2) i_dadc_host_model.sel[ch] <= 1'b0;
      else i_dadc_host_model.cnv[ch] <= 1'b0;
      i_dadc_host_model.idle(5);
      i_dadc_host_model.rd(ch, busy ? 17 : 16, w);
      chk("serial_word", w, {busy & ch_m, res});
      i_dadc_host_model.idle(5);
      chk("oe_release", oe[ch], ch_m);
   endtask
   initial
   begin
      nrst = 1'b0;
      avs_req = '0;
      sample_in = '0;
      num_errors = 0;
      total_checks = 0;
      seed = 32'h2AB5;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("irq_reset", irq, 1'b0);
      chk("pd_reset", pd, 2'h3);
      bus(1'b0, OFS_CTRL, 32'h0, d);
      chk("ctrl_reset", d, 32'h0);
      bus(1'b0, OFS_INT_MASK, 32'h0, d);
      chk("mask_reset", d, 32'h0);
      bus(1'b0, 8'h20, 32'h0, d);
      chk("unmapped", d, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h1, d);
      bus(1'b0, OFS_CTRL, 32'h0, d);
      chk("ctrl_rw", d, 32'h1);
      bus(1'b1, OFS_CTRL, 32'h0, d);
      bus(1'b1, OFS_INT_MASK, 32'h1, d);
      run(0, 0, 18'h00123);
      chk("irq_set", irq, 1'b1);
      bus(1'b0, OFS_INT_STAT, 32'h0, d);
      chk("int_stat", d, 32'h5);
      bus(1'b1, OFS_INT_STAT, 32'h5, d);
      bus(1'b0, OFS_INT_STAT, 32'h0, d);
      chk("int_clear", d, 32'h0);
      chk("irq_clear", irq, 1'b0);
      bus(1'b1, OFS_INT_MASK, 32'h0, d);
      for (int m = 0; m < 7; m++)
      begin
         for (int ch = 0; ch < 2; ch++)
         begin
            seed = xs(seed);
            run(ch, m, m < 4 ? tbl[m] : seed[17:0]);
         end
      end
      // Channel 1 cascades into channel 0, both in chain mode without busy
      bus(1'b1, OFS_CTRL, 32'h1, d);
      seed = xs(seed);
      s0 = seed[17:0];
      seed = xs(seed);
      s1 = seed[17:0];
      sample_in <= {s1, s0};
      i_dadc_host_model.start(1, 1'b0, 1'b0, 1'b0);
      i_dadc_host_model.idle(1);
      i_dadc_host_model.start(0, 1'b0, 1'b0, 1'b0);
      i_dadc_host_model.wait_conv();
      i_dadc_host_model.cnv <= 2'h0;
      i_dadc_host_model.idle(5);
      i_dadc_host_model.rd2(w32);
      chk("cascade", w32, {sat(s0), sat(s1)});
      // Four-line readout cut short by raising the readout select
      i_dadc_host_model.start(0, 1'b1, 1'b0, 1'b0);
      i_dadc_host_model.wait_conv();
      i_dadc_host_model.sel[0] <= 1'b0;
      i_dadc_host_model.idle(5);
      i_dadc_host_model.rd(0, 4, w17);
      i_dadc_host_model.sel[0] <= 1'b1;
      i_dadc_host_model.idle(5);
      chk("partial", w17, 32'(sat(s0) >> 12));
      chk("deselect", oe[0], 1'b0);
      final_report();
   end
endmodule
